// File: design/pbm_cfg.svh
// Constants for the program ROM bank mapper
`ifndef PBM_CFG_SVH
`define PBM_CFG_SVH

`define PBM_PAGE_SEL_ADDR    8'hCA
`define PBM_PAGE_CODE_LSB    0
`define PBM_PAGE_CODE_MSB    3
`define PBM_PAGE_SEL_RST     4'h0
`define PBM_PAGE_READBACK    8'h00
`define PBM_STATIC_PAGE      4'h1
`define PBM_LAST_PAGE        4'h9
`define PBM_HALF_BIT         11
`define PBM_ROM_BYTES        20480
`define PBM_ROM_USER_BYTES   20140
`define PBM_ROM_TEST_BYTES   340
`define PBM_PAGE_BYTES       2048
`define PBM_OOB_FILL         8'hFF
`define PBM_STACK_DEPTH      6
`define PBM_PC_RESET         12'hFFE
`define PBM_VEC_IRQ_LO       12'hFF0
`define PBM_VEC_IRQ_HI       12'hFF7
`define PBM_VEC_NMI_LO       12'hFFC
`define PBM_VEC_NMI_HI       12'hFFD
`define PBM_VEC_RST_LO       12'hFFE
`define PBM_VEC_RST_HI       12'hFFF
`define PBM_P0_TEST_HI       11'h07F
`define PBM_STAT_TEST_LO     12'hFA0
`define PBM_STAT_TEST_HI     12'hFEF
`define PBM_STAT_GAP_LO      12'hFF8
`define PBM_STAT_GAP_HI      12'hFFB
`define PBM_PN_TEST_HI       11'h00F

`endif

// File: design/pbm_pkg.sv
// Types for the program ROM bank mapper
package pbm_pkg;
  typedef logic [11:0] pbm_pc_t;
  typedef logic [14:0] pbm_rom_addr_t;
  typedef logic [3:0]  pbm_page_t;
  typedef logic [2:0]  pbm_depth_t;
  typedef enum logic [2:0] {
    PBM_OP_NONE = 3'h0,
    PBM_OP_INCR = 3'h1,
    PBM_OP_LOAD = 3'h3,
    PBM_OP_PUSH = 3'h2,
    PBM_OP_POP  = 3'h6
  } pbm_op_t;
endpackage

// File: design/pbm_stack_if.sv
// Carrier between the mapper and its return-address stack
`timescale 1ns/10ps
`default_nettype none
interface pbm_stack_if;
  import pbm_pkg::*;
  pbm_op_t    op;
  pbm_pc_t    target;
  pbm_pc_t    pc;
  pbm_depth_t depth;
  modport ctl (output op, output target, input pc, input depth);
  modport stk (input op, input target, output pc, output depth);
endinterface
`default_nettype wire

// File: design/pbm_ret_stack.sv
// Six-level return-address stack whose top entry is the program counter
`timescale 1ns/10ps
`default_nettype none
`include "pbm_cfg.svh"
module pbm_ret_stack
  import pbm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  pbm_stack_if.stk  sif
);
  pbm_pc_t    ent_q [`PBM_STACK_DEPTH];
  pbm_depth_t depth_q;

  // Entry 0 is the live counter; the rest hold return addresses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `PBM_STACK_DEPTH; i++) begin
        ent_q[i] <= `PBM_PC_RESET;
      end
    end else begin
      case (sif.op)
        PBM_OP_INCR: begin
          ent_q[0] <= ent_q[0] + 12'h001; // Wraps inside 4K
        end
        PBM_OP_LOAD: begin
          ent_q[0] <= sif.target;
        end
        PBM_OP_PUSH: begin
          // Deepest return address falls off on overflow
          for (int i = `PBM_STACK_DEPTH - 1; i > 1; i--) begin
            ent_q[i] <= ent_q[i-1];
          end
          ent_q[1] <= ent_q[0] + 12'h001;
          ent_q[0] <= sif.target;
        end
        PBM_OP_POP: begin
          for (int i = 0; i < `PBM_STACK_DEPTH - 1; i++) begin
            ent_q[i] <= ent_q[i+1];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      depth_q <= 3'h0;
    end else if (sif.op == PBM_OP_PUSH && depth_q != 3'(`PBM_STACK_DEPTH - 1)) begin
      depth_q <= depth_q + 3'h1;
    end else if (sif.op == PBM_OP_POP && depth_q != 3'h0) begin
      depth_q <= depth_q - 3'h1;
    end
  end

  assign sif.pc    = ent_q[0];
  assign sif.depth = depth_q;
endmodule
`default_nettype wire

// File: design/pbm_mapper.sv
// Program ROM bank mapper with page register, fetch path and stack
`timescale 1ns/10ps
`default_nettype none
`include "pbm_cfg.svh"
module pbm_mapper
  import pbm_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          data_wr_en,
  input  wire logic          data_rd_en,
  input  wire logic [7:0]    data_addr,
  input  wire logic [7:0]    data_wdata,
  output logic      [7:0]    data_rdata_q,
  output logic               data_hit_q,
  input  wire pbm_op_t       pc_op,
  input  wire pbm_pc_t       pc_target,
  output pbm_pc_t            pc_q,
  output pbm_depth_t         stack_depth_q,
  output pbm_rom_addr_t      rom_addr_q,
  output logic               rom_rd_q,
  input  wire logic [7:0]    rom_rdata,
  output logic      [7:0]    fetch_data_q,
  output logic               fetch_valid_q,
  output logic               fetch_oob_q,
  output logic               fetch_test_area_q,
  output logic               fetch_vector_q,
  output pbm_page_t          page_code_q,
  output logic               page_written_q
);

  // Pages 0 to last fill the ROM exactly
  localparam int unsigned NUM_PAGES = 32'(`PBM_LAST_PAGE) + 1;
  localparam int unsigned MAP_BYTES = NUM_PAGES * `PBM_PAGE_BYTES;
  localparam bit          MAP_OK    = (MAP_BYTES == `PBM_ROM_BYTES) &&
                                      (`PBM_ROM_USER_BYTES + `PBM_ROM_TEST_BYTES == `PBM_ROM_BYTES);

  pbm_stack_if sif ();

  pbm_ret_stack u_stack (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sif     (sif)
  );

  pbm_page_t page_sel_q;
  logic      page_seen_q;
  logic      sel_hit;
  logic      rd_oob_q;
  logic      rd_test_q;
  logic      rd_vec_q;

  // Effective page: bit 11 set means static page
  function automatic pbm_page_t eff_page(input pbm_pc_t pc, input pbm_page_t code);
    pbm_page_t pg;
    if (pc[`PBM_HALF_BIT]) begin
      pg = `PBM_STATIC_PAGE;
    end else begin
      pg = code;
    end
    return pg;
  endfunction

  // Physical address is page number above the 11-bit offset
  function automatic pbm_rom_addr_t phys_addr(input pbm_pc_t pc, input pbm_page_t code);
    return {eff_page(pc, code), pc[10:0]};
  endfunction

  function automatic logic page_oob(input pbm_pc_t pc, input pbm_page_t code);
    return eff_page(pc, code) > `PBM_LAST_PAGE;
  endfunction

  // Test-reserved bytes, which together make the reserved total
  function automatic logic test_area(input pbm_pc_t pc, input pbm_page_t code);
    pbm_page_t pg;
    logic      hit;
    pg  = eff_page(pc, code);
    hit = 1'b0;
    if (pg == 4'h0) begin
      hit = pc[10:0] <= `PBM_P0_TEST_HI;
    end else if (pg == `PBM_STATIC_PAGE) begin
      hit = ({1'b1, pc[10:0]} >= `PBM_STAT_TEST_LO && {1'b1, pc[10:0]} <= `PBM_STAT_TEST_HI) ||
            ({1'b1, pc[10:0]} >= `PBM_STAT_GAP_LO && {1'b1, pc[10:0]} <= `PBM_STAT_GAP_HI);
    end else if (pg <= `PBM_LAST_PAGE) begin
      hit = pc[10:0] <= `PBM_PN_TEST_HI;
    end
    return hit && MAP_OK;
  endfunction

  // Vector slots, reachable whatever page is selected
  function automatic logic vec_area(input pbm_pc_t pc);
    return (pc >= `PBM_VEC_IRQ_LO && pc <= `PBM_VEC_IRQ_HI) ||
           (pc >= `PBM_VEC_NMI_LO && pc <= `PBM_VEC_NMI_HI) ||
           (pc >= `PBM_VEC_RST_LO && pc <= `PBM_VEC_RST_HI);
  endfunction

  assign sel_hit    = data_addr == `PBM_PAGE_SEL_ADDR;
  assign sif.op     = pc_op;
  assign sif.target = pc_target;

  // Only the page code is kept; upper bits have no function
  // Reset value is fixed here although software must not rely on it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      page_sel_q <= `PBM_PAGE_SEL_RST;
    end else if (data_wr_en && sel_hit) begin
      page_sel_q <= data_wdata[`PBM_PAGE_CODE_MSB:`PBM_PAGE_CODE_LSB];
    end
  end

  // Shows whether software has loaded the register since reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      page_seen_q <= 1'b0;
    end else if (data_wr_en && sel_hit) begin
      page_seen_q <= 1'b1;
    end
  end

  // Reads never return the stored code, so read-modify-write breaks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_rdata_q <= 8'h00;
    end else begin
      data_rdata_q <= `PBM_PAGE_READBACK;
    end
  end

  // One pulse per access to the register address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_hit_q <= 1'b0;
    end else begin
      data_hit_q <= (data_rd_en || data_wr_en) && sel_hit;
    end
  end

  // Stage 1: drive the ROM with the mapped address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rom_addr_q <= 15'h0000;
      rom_rd_q   <= 1'b0;
    end else begin
      rom_addr_q <= phys_addr(sif.pc, page_sel_q);
      rom_rd_q   <= !page_oob(sif.pc, page_sel_q);
    end
  end

  // Stage 1 flags travel alongside the address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_oob_q  <= 1'b0;
      rd_test_q <= 1'b0;
      rd_vec_q  <= 1'b0;
    end else begin
      rd_oob_q  <= page_oob(sif.pc, page_sel_q);
      rd_test_q <= test_area(sif.pc, page_sel_q);
      rd_vec_q  <= vec_area(sif.pc);
    end
  end

  // Stage 2: capture ROM data; missing pages read as a fixed byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_data_q  <= 8'h00;
      fetch_valid_q <= 1'b0;
    end else begin
      fetch_data_q  <= rd_oob_q ? `PBM_OOB_FILL : rom_rdata;
      fetch_valid_q <= 1'b1;
    end
  end

  // Stage 2 flags line up with the fetched byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_oob_q       <= 1'b0;
      fetch_test_area_q <= 1'b0;
      fetch_vector_q    <= 1'b0;
    end else begin
      fetch_oob_q       <= rd_oob_q;
      fetch_test_area_q <= rd_test_q;
      fetch_vector_q    <= rd_vec_q;
    end
  end

  // Status copies, registered so outputs come from flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_q          <= `PBM_PC_RESET;
      stack_depth_q <= 3'h0;
    end else begin
      pc_q          <= sif.pc;
      stack_depth_q <= sif.depth;
    end
  end

  // Page copies for observation only; software cannot read them back
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      page_code_q    <= `PBM_PAGE_SEL_RST;
      page_written_q <= 1'b0;
    end else begin
      page_code_q    <= page_sel_q;
      page_written_q <= page_seen_q;
    end
  end

endmodule
`default_nettype wire

// File: dv/pbm_rom_model.sv
// Behavioural program ROM facing the mapper
`timescale 1ns/10ps
`default_nettype none
module pbm_rom_model
  import pbm_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire pbm_rom_addr_t rom_addr_q,
  input  wire logic          rom_rd_q,
  output logic [7:0]         rom_rdata
);
  logic [7:0] last_q;
  // Byte depends on page and offset, so aliases show
  always_comb rom_rdata = rom_rd_q ? (rom_addr_q[7:0] ^ {1'b0, rom_addr_q[14:8]}) : ~last_q;
  // Deselected ROM must not repeat a stale byte
  always_ff @(posedge ref_clk) last_q <= rom_rdata;
endmodule
`default_nettype wire

// File: dv/pbm_mapper_assertions.sv
// Checker on the mapper's ports
`timescale 1ns/10ps
`default_nettype none
module pbm_mapper_assertions
  import pbm_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          data_wr_en,
  input wire logic          data_rd_en,
  input wire logic [7:0]    data_addr,
  input wire logic [7:0]    data_rdata_q,
  input wire logic          data_hit_q,
  input wire pbm_op_t       pc_op,
  input wire pbm_pc_t       pc_target,
  input wire pbm_pc_t       pc_q,
  input wire pbm_rom_addr_t rom_addr_q,
  input wire logic          rom_rd_q,
  input wire logic [7:0]    rom_rdata,
  input wire logic [7:0]    fetch_data_q,
  input wire logic          fetch_valid_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = (data_wr_en || data_rd_en) && data_addr == 8'hCA;
  chk_hit_pulse: assert property (acc |=> data_hit_q)
    else $error("no hit after access");
  chk_hit_other: assert property (!acc |=> !data_hit_q)
    else $error("stray hit");
  chk_read_zero: assert property (data_rdata_q == 8'h00)
    else $error("read data not zero");
  // Guarded by valid: first sample after reset still sees reset values
  chk_addr_offset: assert property (fetch_valid_q |-> rom_addr_q[10:0] == pc_q[10:0])
    else $error("offset differs from pc");
  chk_upper_static: assert property (fetch_valid_q && pc_q[11] |-> rom_addr_q[14:11] == 4'h1 && rom_rd_q)
    else $error("upper half not static");
  chk_fetch_byte: assert property (fetch_valid_q && rom_rd_q |=> fetch_data_q == $past(rom_rdata))
    else $error("fetch byte wrong");
  chk_oob_fill: assert property (fetch_valid_q && !rom_rd_q |=> fetch_data_q == 8'hFF)
    else $error("no fill value");
  chk_load_pc: assert property (pc_op inside {PBM_OP_LOAD, PBM_OP_PUSH} |-> ##2 pc_q == $past(pc_target, 2))
    else $error("pc not loaded");
  cover property (acc && data_wr_en);
  cover property (fetch_valid_q && !rom_rd_q);
  cover property (pc_op == PBM_OP_POP);
endmodule
bind pbm_mapper pbm_mapper_assertions u_chk (.ref_clk, .rst, .data_wr_en, .data_rd_en, .data_addr,
  .data_rdata_q, .data_hit_q, .pc_op, .pc_target, .pc_q, .rom_addr_q, .rom_rd_q, .rom_rdata,
  .fetch_data_q, .fetch_valid_q);
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the bank mapper
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pbm_pkg::*;
  logic          ref_clk, rst, data_wr_en, data_rd_en, data_hit_q, rom_rd_q, page_written_q;
  logic          fetch_valid_q, fetch_oob_q, fetch_test_area_q, fetch_vector_q;
  logic [7:0]    data_addr, data_wdata, data_rdata_q, rom_rdata, fetch_data_q;
  pbm_op_t       pc_op;
  pbm_pc_t       pc_target, pc_q;
  pbm_depth_t    stack_depth_q;
  pbm_rom_addr_t rom_addr_q;
  pbm_page_t     page_code_q;
  int            failures, n_compared;
  pbm_mapper dut (.ref_clk, .rst, .data_wr_en, .data_rd_en, .data_addr, .data_wdata, .data_rdata_q,
    .data_hit_q, .pc_op, .pc_target, .pc_q, .stack_depth_q, .rom_addr_q, .rom_rd_q, .rom_rdata,
    .fetch_data_q, .fetch_valid_q, .fetch_oob_q, .fetch_test_area_q, .fetch_vector_q,
    .page_code_q, .page_written_q);
  pbm_rom_model rom (.ref_clk, .rom_addr_q, .rom_rd_q, .rom_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    @(negedge ref_clk);
    {data_wr_en, data_rd_en, data_addr, data_wdata} = {wr, !wr, addr, wd};
    @(negedge ref_clk);
    cmp("hit", 16'(addr == 8'hCA), 16'(data_hit_q));
    cmp("rdata", 16'h0000, 16'(data_rdata_q));
    {data_wr_en, data_rd_en} = 2'b00;
  endtask
  // Op held for one edge only; later edges see NONE, which holds the pc
  task automatic jump(input pbm_op_t op, input pbm_pc_t t);
    @(negedge ref_clk);
    pc_op = op;
    pc_target = t;
    @(negedge ref_clk);
    pc_op = PBM_OP_NONE;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic fetch_chk(input pbm_page_t pg, input pbm_pc_t pc);
    logic [14:0] a;
    logic [10:0] o;
    a = {pg, pc[10:0]};
    o = pc[10:0];
    cmp("pc", 16'(pc), 16'(pc_q));
    cmp("rom_rd", 16'(pg <= 4'h9), 16'(rom_rd_q));
    if (pg <= 4'h9) cmp("rom_addr", 16'(a), 16'(rom_addr_q));
    cmp("fetch", pg <= 4'h9 ? 16'(a[7:0] ^ {1'b0, a[14:8]}) : 16'h00FF, 16'(fetch_data_q));
    cmp("oob", 16'(pg > 4'h9), 16'(fetch_oob_q));
    cmp("vector", 16'(pc >= 12'hFF0 && pc != 12'hFF8 && pc != 12'hFF9 && pc != 12'hFFA && pc != 12'hFFB),
      16'(fetch_vector_q));
    cmp("test_area", 16'((pg == 4'h0 && o <= 11'h07F) || (pg == 4'h1 && ((o >= 11'h7A0 && o <= 11'h7EF)
      || (o >= 11'h7F8 && o <= 11'h7FB))) || (pg >= 4'h2 && pg <= 4'h9 && o <= 11'h00F)),
      16'(fetch_test_area_q));
  endtask
  task automatic t_reset;
    repeat (2) @(negedge ref_clk);
    cmp("written", 16'h0000, 16'(page_written_q));
    cmp("valid", 16'h0001, 16'(fetch_valid_q));
    fetch_chk(4'h1, 12'hFFE);
  endtask
  task automatic t_rerst;
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    cmp("page_code", 16'h0000, 16'(page_code_q));
  endtask
  task automatic t_pages;
    pbm_pc_t pc;
    for (int c = 0; c < 16; c++) begin
      pc = {1'b0, c[0] ? 7'h7A : 7'h04, c[3:0]};
      access(1'b1, 8'hCA, {4'h0, c[3:0]});
      jump(PBM_OP_LOAD, pc);
      fetch_chk(c[3:0], pc);
      cmp("page_code", 16'(c[3:0]), 16'(page_code_q));
    end
    cmp("written", 16'h0001, 16'(page_written_q));
  endtask
  task automatic t_static;
    logic [7:0] image;
    image = 8'h05;
    access(1'b1, 8'hCA, image);
    access(1'b1, 8'hC9, 8'h02);
    access(1'b0, 8'hCA, 8'h00);
    jump(PBM_OP_LOAD, 12'hFF0);
    fetch_chk(4'h1, 12'hFF0);
    jump(PBM_OP_LOAD, 12'h234);
    fetch_chk(4'h5, 12'h234);
    cmp("page_code", 16'h0005, 16'(page_code_q));
  endtask
  task automatic t_stack;
    jump(PBM_OP_LOAD, 12'h100);
    jump(PBM_OP_PUSH, 12'h800);
    cmp("depth", 16'h0001, 16'(stack_depth_q));
    fetch_chk(4'h1, 12'h800);
    jump(PBM_OP_POP, 12'h000);
    cmp("depth", 16'h0000, 16'(stack_depth_q));
    fetch_chk(4'h5, 12'h101);
    jump(PBM_OP_INCR, 12'h000);
    fetch_chk(4'h5, 12'h102);
    jump(PBM_OP_LOAD, 12'hFFF);
    jump(PBM_OP_INCR, 12'h000);
    fetch_chk(4'h5, 12'h000);
    repeat (7) jump(PBM_OP_PUSH, 12'h900);
    cmp("depth", 16'h0005, 16'(stack_depth_q));
  endtask
  initial begin
    {rst, data_wr_en, data_rd_en, data_addr, data_wdata, pc_target} = '1;
    {data_wr_en, data_rd_en} = 2'b00;
    pc_op = PBM_OP_NONE;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_pages();
    t_static();
    t_stack();
    t_rerst();
    complete_run();
  end
  initial begin
    #50000;
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
